// File: hdl/rcsw_clock_switch.sv
// Run clock switch between primary and internal RC oscillator, APB slave
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "rcsw_params.svh"

// Contract
// - Select 11 runs everything from internal RC
// - On internal RC, stop primary, clear running flag
// - Leaving internal mode, stay on RC meanwhile
// - Primary ready: switch over and set running flag in the same cycle
// - Switch never alters select or idle bits
// - Keep RC alive for watchdog or monitor
module rcsw_clock_switch (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        i_primary_ready,
   input  wire logic        i_wdt_en,
   input  wire logic        i_fscm_en,
   output logic             o_sel_primary,
   output logic             o_sel_internal,
   output logic             o_primary_osc_en,
   output logic             o_internal_osc_en,
   output logic             o_primary_running,
   output logic             o_idle_on_sleep
);

   // =====================================================================
   // Declarations
   rcsw_pkg::rcsw_state_e state;
   rcsw_pkg::rcsw_state_e next_state;
   logic [1:0]  gap_cnt;
   logic [1:0]  next_gap_cnt;
   logic [1:0]  clock_select_field;
   logic [1:0]  next_clock_select_field;
   logic        idle_on_sleep_enable;
   logic        next_idle_on_sleep_enable;
   logic        next_sel_primary;
   logic        next_sel_internal;
   logic        next_primary_osc_en;
   logic        next_internal_osc_en;
   logic        next_running;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        setup;
   logic        wr_ctrl;
   logic        want_internal;

   // Address decode, used only by the error response on unmapped addresses
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `RCSW_CTRL_OFS) || (a == `RCSW_STATUS_OFS);
   endfunction

   assign setup         = psel && !penable;
   assign wr_ctrl       = psel && penable && pready && pwrite &&
                          (paddr == `RCSW_CTRL_OFS);
   assign want_internal = (clock_select_field == `RCSW_SEL_INTERNAL);

   // =====================================================================
   // Control register, changed by software writes only
   always_comb begin
      next_clock_select_field   = clock_select_field;
      next_idle_on_sleep_enable = idle_on_sleep_enable;
      if (wr_ctrl) begin
         next_clock_select_field   = pwdata[`RCSW_SEL_MSB:`RCSW_SEL_LSB];
         next_idle_on_sleep_enable = pwdata[`RCSW_IDLE_BIT];
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         clock_select_field   <= `RCSW_SEL_RST;
         idle_on_sleep_enable <= `RCSW_IDLE_RST;
      end else begin
         clock_select_field   <= next_clock_select_field;
         idle_on_sleep_enable <= next_idle_on_sleep_enable;
      end
   end

   // =====================================================================
   // APB answer: zero wait states, error on unmapped address
   always_comb begin
      next_pready  = setup;
      next_pslverr = setup && !is_mapped(paddr);
      next_prdata  = 32'h0;
      if (setup && !pwrite) begin
         if (paddr == `RCSW_CTRL_OFS) begin
            next_prdata[`RCSW_SEL_MSB:`RCSW_SEL_LSB] = clock_select_field;
            next_prdata[`RCSW_IDLE_BIT] = idle_on_sleep_enable;
         end else if (paddr == `RCSW_STATUS_OFS) begin
            next_prdata[`RCSW_ST_SEL_PRI] = o_sel_primary;
            next_prdata[`RCSW_ST_SEL_INT] = o_sel_internal;
            next_prdata[`RCSW_ST_PRI_OSC] = o_primary_osc_en;
            next_prdata[`RCSW_ST_RUNNING] = o_primary_running;
            next_prdata[`RCSW_ST_INT_OSC] = o_internal_osc_en;
            next_prdata[`RCSW_ST_BUSY]    = (state != rcsw_pkg::RCSW_PRI) &&
                                            (state != rcsw_pkg::RCSW_RC);
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // =====================================================================
   // Clock switch sequencer
   always_comb begin
      next_state           = state;
      next_gap_cnt         = 2'h0;
      next_sel_primary     = 1'b0;
      next_sel_internal    = 1'b0;
      next_primary_osc_en  = 1'b1;
      next_running         = 1'b0;
      case (state)
         rcsw_pkg::RCSW_PRI: begin
            next_sel_primary = 1'b1;
            next_running     = 1'b1;
            if (want_internal) begin
               next_state       = rcsw_pkg::RCSW_GAP_RC;
               next_sel_primary = 1'b0;
               next_running     = 1'b0;
            end
         end
         rcsw_pkg::RCSW_GAP_RC: begin
            next_gap_cnt = gap_cnt + 2'h1;
            if (gap_cnt == `RCSW_GAP_CYC - 2'h1) begin
               next_state          = rcsw_pkg::RCSW_RC;
               next_gap_cnt        = 2'h0;
               next_sel_internal   = 1'b1;
               next_primary_osc_en = 1'b0;
            end
         end
         rcsw_pkg::RCSW_RC: begin
            next_sel_internal   = 1'b1;
            next_primary_osc_en = 1'b0;
            if (!want_internal) begin
               next_state          = rcsw_pkg::RCSW_WAIT_PRI;
               next_primary_osc_en = 1'b1;
            end
         end
         rcsw_pkg::RCSW_WAIT_PRI: begin
            next_sel_internal = 1'b1;
            if (want_internal) begin
               next_state          = rcsw_pkg::RCSW_RC;
               next_primary_osc_en = 1'b0;
            end else if (i_primary_ready) begin
               next_state        = rcsw_pkg::RCSW_GAP_PRI;
               next_sel_internal = 1'b0;
            end
         end
         rcsw_pkg::RCSW_GAP_PRI: begin
            next_gap_cnt = gap_cnt + 2'h1;
            if (gap_cnt == `RCSW_GAP_CYC - 2'h1) begin
               next_state       = rcsw_pkg::RCSW_PRI;
               next_gap_cnt     = 2'h0;
               next_sel_primary = 1'b1;
               next_running     = 1'b1;
            end
         end
         default: begin
            next_state = rcsw_pkg::RCSW_PRI;
         end
      endcase
      // RC runs while in use or needed by watchdog or monitor
      next_internal_osc_en = (next_state != rcsw_pkg::RCSW_PRI) ||
                             i_wdt_en || i_fscm_en;
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state             <= rcsw_pkg::RCSW_PRI;
         gap_cnt           <= 2'h0;
         o_sel_primary     <= 1'b1;
         o_sel_internal    <= 1'b0;
         o_primary_osc_en  <= 1'b1;
         o_internal_osc_en <= 1'b1;
         o_primary_running <= 1'b1;
         o_idle_on_sleep   <= `RCSW_IDLE_RST;
      end else begin
         state             <= next_state;
         gap_cnt           <= next_gap_cnt;
         o_sel_primary     <= next_sel_primary;
         o_sel_internal    <= next_sel_internal;
         o_primary_osc_en  <= next_primary_osc_en;
         o_internal_osc_en <= next_internal_osc_en;
         o_primary_running <= next_running;
         o_idle_on_sleep   <= next_idle_on_sleep_enable;
      end
   end

   // =====================================================================
   // Assertions
   property p_enter_internal;
      @(posedge i_clk) disable iff (i_sys_rst)
      (state == rcsw_pkg::RCSW_PRI) && want_internal |=>
         ##[1:4] (o_sel_internal && !o_sel_primary);
   endproperty
   a_enter_internal: assert property (p_enter_internal)
      else $error("internal clock not selected after select 11");

   property p_primary_off;
      @(posedge i_clk) disable iff (i_sys_rst)
      (state == rcsw_pkg::RCSW_RC) |->
         (!o_primary_osc_en && !o_primary_running && o_sel_internal);
   endproperty
   a_primary_off: assert property (p_primary_off)
      else $error("primary still on in internal run mode");

   property p_stay_on_rc;
      @(posedge i_clk) disable iff (i_sys_rst)
      (state == rcsw_pkg::RCSW_RC) && !want_internal |=>
         (o_sel_internal && o_primary_osc_en && !o_sel_primary);
   endproperty
   a_stay_on_rc: assert property (p_stay_on_rc)
      else $error("left internal clock before primary ready");

   property p_switch_back;
      @(posedge i_clk) disable iff (i_sys_rst)
      (state == rcsw_pkg::RCSW_WAIT_PRI) && !want_internal &&
      i_primary_ready |=> ##[1:4] (o_sel_primary && o_primary_running);
   endproperty
   a_switch_back: assert property (p_switch_back)
      else $error("no switch to primary after ready");

   property p_flag_with_switch;
      @(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_primary_running) |-> $rose(o_sel_primary);
   endproperty
   a_flag_with_switch: assert property (p_flag_with_switch)
      else $error("running flag set apart from switch");

   property p_ctrl_stable;
      @(posedge i_clk) disable iff (i_sys_rst)
      !wr_ctrl |=> ($stable(clock_select_field) &&
                    $stable(idle_on_sleep_enable));
   endproperty
   a_ctrl_stable: assert property (p_ctrl_stable)
      else $error("control bits changed without a write");

   property p_rc_kept;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_wdt_en || i_fscm_en) |=> o_internal_osc_en;
   endproperty
   a_rc_kept: assert property (p_rc_kept)
      else $error("internal oscillator stopped while needed");

   property p_break_gap;
      @(posedge i_clk) disable iff (i_sys_rst)
      ($fell(o_sel_primary) || $fell(o_sel_internal)) |->
         (!o_sel_primary && !o_sel_internal) [*2];
   endproperty
   a_break_gap: assert property (p_break_gap)
      else $error("clock gates not both closed for dead time");

   property p_back_to_rc;
      @(posedge i_clk) disable iff (i_sys_rst)
      (state == rcsw_pkg::RCSW_WAIT_PRI) && want_internal |=>
         (!o_primary_osc_en && o_sel_internal && !o_primary_running);
   endproperty
   a_back_to_rc: assert property (p_back_to_rc)
      else $error("primary not stopped on return to internal");

   property p_rc_released;
      @(posedge i_clk) disable iff (i_sys_rst)
      (state == rcsw_pkg::RCSW_PRI) && !want_internal && !i_wdt_en &&
      !i_fscm_en |=> !o_internal_osc_en;
   endproperty
   a_rc_released: assert property (p_rc_released)
      else $error("internal oscillator left running with no user");

   property p_gate_needs_osc;
      @(posedge i_clk) disable iff (i_sys_rst)
      o_sel_primary |-> (o_primary_osc_en && o_primary_running);
   endproperty
   a_gate_needs_osc: assert property (p_gate_needs_osc)
      else $error("primary gate open without oscillator or flag");

   property p_rc_in_use;
      @(posedge i_clk) disable iff (i_sys_rst)
      o_sel_internal |-> (o_internal_osc_en && !o_primary_running);
   endproperty
   a_rc_in_use: assert property (p_rc_in_use)
      else $error("internal gate open without its oscillator");

   property p_idle_copy;
      @(posedge i_clk) disable iff (i_sys_rst)
      !wr_ctrl |=> $stable(o_idle_on_sleep);
   endproperty
   a_idle_copy: assert property (p_idle_copy)
      else $error("idle enable output changed without a write");

endmodule
`default_nettype wire

// File: hdl/rcsw_params.svh
// Offsets, field positions, reset values and counts of the clock switch
`ifndef RCSW_PARAMS_SVH
`define RCSW_PARAMS_SVH

// =====================================================================
// Register byte offsets
`define RCSW_CTRL_OFS      12'h000
`define RCSW_STATUS_OFS    12'h004

// =====================================================================
// Control word fields
`define RCSW_SEL_LSB       0
`define RCSW_SEL_MSB       1
`define RCSW_IDLE_BIT      7
`define RCSW_SEL_INTERNAL  2'h3
`define RCSW_SEL_RST       2'h0
`define RCSW_IDLE_RST      1'h0

// =====================================================================
// Status word fields
`define RCSW_ST_SEL_PRI    0
`define RCSW_ST_SEL_INT    1
`define RCSW_ST_PRI_OSC    2
`define RCSW_ST_RUNNING    3
`define RCSW_ST_INT_OSC    4
`define RCSW_ST_BUSY       5

// =====================================================================
// Dead time with both clock gates closed, in cycles
`define RCSW_GAP_CYC       2'h2

`endif

// File: hdl/rcsw_pkg.sv
// Types shared by the clock switch
package rcsw_pkg;

   // =====================================================================
   // Switch state, one-hot
   typedef enum logic [4:0] {
      RCSW_PRI      = 5'h01,
      RCSW_GAP_RC   = 5'h02,
      RCSW_RC       = 5'h04,
      RCSW_WAIT_PRI = 5'h08,
      RCSW_GAP_PRI  = 5'h10
   } rcsw_state_e;

endpackage

// File: sim/internal_internal_clock_run_mode_clock_switch_tb.sv
// Self-checking bench for the run clock switch over its register bus
`timescale 1ns/10ps
`default_nettype none
`include "rcsw_params.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end

module internal_internal_clock_run_mode_clock_switch_tb;
   logic        i_clk;
   logic        i_sys_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        i_primary_ready;
   logic        i_wdt_en;
   logic        i_fscm_en;
   logic        o_sel_primary;
   logic        o_sel_internal;
   logic        o_primary_osc_en;
   logic        o_internal_osc_en;
   logic        o_primary_running;
   logic        o_idle_on_sleep;
   int          mismatches;
   int          checked;
   int          cycles;
   logic [31:0] rd;
   logic        err;

   rcsw_clock_switch DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .i_primary_ready(i_primary_ready),
      .i_wdt_en(i_wdt_en), .i_fscm_en(i_fscm_en),
      .o_sel_primary(o_sel_primary), .o_sel_internal(o_sel_internal),
      .o_primary_osc_en(o_primary_osc_en),
      .o_internal_osc_en(o_internal_osc_en),
      .o_primary_running(o_primary_running),
      .o_idle_on_sleep(o_idle_on_sleep));

   // =====================================================================
   // Clock, timeout and closing report
   initial i_clk = 1'b0;
   always #20 i_clk = ~i_clk;

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   always @(posedge i_clk) begin
      cycles++;
      if (cycles >= 3000) begin
         mismatches++;
         stop_test();
      end
   end

   // Both clock gates must never be open together
   always @(posedge i_clk) begin
      if (!i_sys_rst) `CHK(o_sel_primary & o_sel_internal, 1'b0)
   end

   // =====================================================================
   // Bus transfer: setup, access held until pready sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge i_clk);
      penable <= 1'b1;
      @(posedge i_clk);
      while (pready !== 1'b1) begin
         @(posedge i_clk);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clk);
   endtask

   // Wait until a gate enable reaches a level, bounded
   task automatic wait_gate(input logic internal, input logic lvl);
      int n;
      n = 0;
      while ((internal ? o_sel_internal : o_sel_primary) !== lvl
             && n < 50) begin
         n++;
         @(posedge i_clk);
      end
   endtask

   // =====================================================================
   // Main sequence
   initial begin
      mismatches = 0;
      checked = 0;
      cycles = 0;
      i_sys_rst = 1'b1;
      {psel, penable, pwrite} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      {i_primary_ready, i_wdt_en, i_fscm_en} = 3'h0;
      repeat (4) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      repeat (3) @(posedge i_clk);
      // Start on primary, internal oscillator idle
      apb(1'b0, `RCSW_STATUS_OFS, 32'h0);
      `CHK(rd, 32'h0000_000d)
      apb(1'b0, 12'h008, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b1, `RCSW_STATUS_OFS, 32'hffff_ffff);
      apb(1'b0, `RCSW_STATUS_OFS, 32'h0);
      `CHK(rd, 32'h0000_000d)
      // Enter internal clock run mode with idle enable set
      apb(1'b1, `RCSW_CTRL_OFS, 32'h0000_0083);
      wait_gate(1'b1, 1'b1);
      `CHK({o_sel_internal, o_sel_primary}, 2'h2)
      `CHK({o_primary_osc_en, o_primary_running}, 2'h0)
      apb(1'b0, `RCSW_STATUS_OFS, 32'h0);
      `CHK(rd, 32'h0000_0012)
      apb(1'b0, `RCSW_CTRL_OFS, 32'h0);
      `CHK(rd, 32'h0000_0083)
      // Return to primary, oscillator not yet ready
      i_wdt_en <= 1'b1;
      apb(1'b1, `RCSW_CTRL_OFS, 32'h0000_0080);
      repeat (10) @(posedge i_clk);
      `CHK({o_sel_internal, o_sel_primary}, 2'h2)
      `CHK({o_primary_osc_en, o_primary_running}, 2'h2)
      i_primary_ready <= 1'b1;
      @(posedge i_clk);
      wait_gate(1'b0, 1'b1);
      `CHK({o_sel_primary, o_primary_running}, 2'h3)
      `CHK(o_sel_internal, 1'b0)
      `CHK(o_idle_on_sleep, 1'b1)
      apb(1'b0, `RCSW_CTRL_OFS, 32'h0);
      `CHK(rd, 32'h0000_0080)
      apb(1'b0, `RCSW_STATUS_OFS, 32'h0);
      `CHK(rd, 32'h0000_001d)
      // Internal oscillator kept alive by the monitor, released when neither user needs it
      i_wdt_en <= 1'b0;
      i_fscm_en <= 1'b1;
      repeat (3) @(posedge i_clk);
      `CHK(o_internal_osc_en, 1'b1)
      i_fscm_en <= 1'b0;
      repeat (3) @(posedge i_clk);
      `CHK(o_internal_osc_en, 1'b0)
      // Field back to 11 while waiting for ready keeps internal clock
      i_primary_ready <= 1'b0;
      apb(1'b1, `RCSW_CTRL_OFS, 32'h0000_0003);
      wait_gate(1'b1, 1'b1);
      apb(1'b1, `RCSW_CTRL_OFS, 32'h0000_0001);
      apb(1'b0, `RCSW_STATUS_OFS, 32'h0);
      `CHK(rd, 32'h0000_0036)
      apb(1'b1, `RCSW_CTRL_OFS, 32'h0000_0003);
      @(posedge i_clk);
      `CHK({o_primary_osc_en, o_sel_internal}, 2'h1)
      apb(1'b0, `RCSW_CTRL_OFS, 32'h0);
      `CHK(rd, 32'h0000_0003)
      // Field value 10 also means primary
      apb(1'b1, `RCSW_CTRL_OFS, 32'h0000_0002);
      i_primary_ready <= 1'b1;
      wait_gate(1'b0, 1'b1);
      `CHK({o_sel_primary, o_primary_running}, 2'h3)
      stop_test();
   end
endmodule
`default_nettype wire
